// *** core/dgc_pkg.sv ***
/*
 * Constants, register layout and state type of the deserializer's two
 * general configuration registers and the logic they steer.
 * Assumes one 250 MHz system clock and a byte-wide register port fed by
 * the device's serial control slave.
 */
package dgc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_RESET = 8'h01;
    localparam logic [7:0] ADDR_CFG0  = 8'h02;
    localparam logic [7:0] ADDR_CFG1  = 8'h03;

    // Reset values
    localparam logic [7:0] CFG0_RST = 8'h80;
    localparam logic [7:0] CFG1_RST = 8'hf0;

    // Field positions, first register
    localparam int C0_OE_VAL  = 7;
    localparam int C0_OVR     = 6;
    localparam int C0_OSC_EN  = 5;
    localparam int C0_SLEEP   = 4;
    // Field positions, second register
    localparam int C1_CRC_EN  = 6;
    localparam int C1_PULL_DN = 5;
    localparam int C1_FILT_EN = 4;
    localparam int C1_PASS    = 3;
    localparam int C1_AUTOACK = 2;
    localparam int C1_GATE    = 1;
    // Field position, logic reset bit in the reset register
    localparam int RST_KEEP   = 0;

    // Filter depths in pixel clocks
    localparam logic [2:0] FILT_DEPTH_1L = 3'h2;
    localparam logic [2:0] FILT_DEPTH_2L = 3'h4;

    // Logic reset settle time
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int LRST_TIME_PS    = 500000000;
    localparam int LRST_CYCLES     =
        (LRST_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LRST_W          = 17;

    // Sync and valid lanes of the filter
    localparam int SIG_VALID = 0;
    localparam int SIG_LINE  = 1;
    localparam int SIG_FRAME = 2;

    // Pixel-side group entering the block
    typedef struct packed {
        logic        pix_en;
        logic        pixel_valid;
        logic        line_sync;
        logic        frame_sync;
        logic [23:0] data;
    } dgc_pix_type;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]           cfg0;
        logic [7:0]           cfg1;
        logic [7:0]           rdata;
        logic                 rvalid;
        logic                 out_en;
        logic                 sleep_sel;
        logic                 pix_clk;
        logic                 crc_en;
        logic                 pull_dn;
        logic                 fwd;
        logic                 auto_ack;
        logic [2:0][2:0]      cnt;
        logic [2:0]           filt;
        logic [23:0]          pix_data;
        logic                 lrst;
        logic [LRST_W-1:0]    busy;
        logic                 busy_out;
    } dgc_state_type;

endpackage

// *** core/dgc_regs.sv ***
/*
 * General configuration register pair and the logic they steer: output
 * enable and sleep selection, oscillator fallback on the pixel clock,
 * sync/valid glitch filter, pixel gating and serial control options.
 * Assumes a register port already decoded from the serial control slave,
 * and pixel-side inputs synchronous to the system clock with a pixel
 * clock enable pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module dgc_regs #(
    parameter int LRST_COUNT = dgc_pkg::LRST_CYCLES
) (
    // Clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rstn,
    // Register port
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire logic [7:0]         i_reg_addr,
    input  wire logic [7:0]         i_reg_wdata,
    output var  logic [7:0]         o_reg_rdata,
    output var  logic               o_reg_rvalid,
    // Link status
    input  wire logic               i_lock,
    input  wire logic               i_dual_lane,
    input  wire logic               i_ser_protected,
    input  wire logic               i_addr_match,
    // Clock sources, levels sampled on the system clock
    input  wire logic               i_pix_clk_lvl,
    input  wire logic               i_osc_clk_lvl,
    // Pixel side
    input  wire dgc_pkg::dgc_pix_type i_pix,
    // Output controls
    output var  logic               o_out_en,
    output var  logic               o_sleep_sel,
    output var  logic               o_pix_clk,
    output var  logic               o_return_link_checksum_en,
    output var  logic               o_undriven_pull_down_sel,
    output var  logic               o_fwd_ctrl,
    output var  logic               o_auto_ack_en,
    output var  logic               o_logic_reset,
    output var  logic               o_logic_reset_busy,
    // Filtered sync and gated data
    output var  logic               o_pixel_valid,
    output var  logic               o_line_sync,
    output var  logic               o_frame_sync,
    output var  logic [23:0]        o_pix_data
);
    import dgc_pkg::*;

    localparam logic [LRST_W-1:0] LRST_LOAD = LRST_W'(LRST_COUNT);

    dgc_state_type q;
    dgc_state_type d;
    logic [2:0]    sig_in;
    logic [2:0]    depth;
    logic          gate_on;

    // One filter lane step: returns {filtered level, count}
    function automatic logic [3:0] filt_step(
        input logic       sig,
        input logic       filt,
        input logic [2:0] cnt,
        input logic [2:0] dep,
        input logic       en,
        input logic       tick
    );
        logic [2:0] nxt;
        nxt = cnt + 3'h1;
        if (!en) begin
            filt_step = {sig, 3'h0};
        end else if (sig == filt) begin
            filt_step = {filt, 3'h0};
        end else if (!tick) begin
            filt_step = {filt, cnt};
        end else if (nxt >= dep) begin
            filt_step = {sig, 3'h0};
        end else begin
            filt_step = {filt, nxt};
        end
    endfunction

    // Lane inputs, depth and gating selection
    assign sig_in  = {i_pix.frame_sync, i_pix.line_sync, i_pix.pixel_valid};
    assign depth   = i_dual_lane ? FILT_DEPTH_2L : FILT_DEPTH_1L;
    assign gate_on = q.cfg1[C1_GATE] | i_ser_protected;

    // Next state
    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        d.lrst   = 1'b0;
        // Register writes; reserved bits store what is written
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_CFG0: begin
                    d.cfg0 = i_reg_wdata;
                end
                ADDR_CFG1: begin
                    d.cfg1 = i_reg_wdata;
                end
                ADDR_RESET: begin
                    d.lrst = i_reg_wdata[RST_KEEP];
                end
                default: begin
                    d.cfg0 = q.cfg0;
                end
            endcase
        end
        // Register reads, unmapped offsets answer zero
        if (i_reg_rd) begin
            d.rvalid = 1'b1;
            case (i_reg_addr)
                ADDR_CFG0: begin
                    d.rdata = q.cfg0;
                end
                ADDR_CFG1: begin
                    d.rdata = q.cfg1;
                end
                ADDR_RESET: begin
                    d.rdata = 8'h00; // Logic reset bit self-clears
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
        // Logic reset keeps registers and holds busy for the settle time
        if (q.lrst) begin
            d.busy = LRST_LOAD;
        end else if (q.busy != '0) begin
            d.busy = q.busy - LRST_W'(1);
        end
        d.busy_out = d.busy != '0; // Busy flag kept in its own flop
        // Effective output enable and sleep state
        d.out_en    = q.cfg0[C0_OVR] ? q.cfg0[C0_OE_VAL] : 1'b1;
        d.sleep_sel = q.cfg0[C0_OVR] ? q.cfg0[C0_SLEEP] : 1'b1;
        // Pixel clock or oscillator fallback when lock is lost
        if (i_lock) begin
            d.pix_clk = i_pix_clk_lvl;
        end else begin
            d.pix_clk = q.cfg0[C0_OSC_EN] & i_osc_clk_lvl;
        end
        // Control outputs from their bits, forwarding also gated by address match
        d.crc_en   = q.cfg1[C1_CRC_EN];
        d.pull_dn  = q.cfg1[C1_PULL_DN];
        d.fwd      = q.cfg1[C1_PASS] & i_addr_match;
        d.auto_ack = q.cfg1[C1_AUTOACK];
        // Glitch filter on valid, line and frame sync
        for (int k = 0; k < 3; k++) begin
            {d.filt[k], d.cnt[k]} = filt_step(sig_in[k], q.filt[k],
                q.cnt[k], depth, q.cfg1[C1_FILT_EN], i_pix.pix_en);
        end
        // Pixel data gating with filtered valid
        d.pix_data = (gate_on && !d.filt[SIG_VALID]) ? 24'h000000
                                                     : i_pix.data;
        // Logic reset clears the datapath, registers untouched
        if (q.lrst) begin
            d.filt     = 3'h0;
            d.cnt      = '0;
            d.pix_data = 24'h000000;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            q           <= '0;
            q.cfg0      <= CFG0_RST;
            q.cfg1      <= CFG1_RST;
            q.out_en    <= 1'b1;
            q.sleep_sel <= 1'b1;
            q.crc_en    <= 1'b1;
            q.pull_dn   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state
    assign o_reg_rdata               = q.rdata;
    assign o_reg_rvalid              = q.rvalid;
    assign o_out_en                  = q.out_en;
    assign o_sleep_sel               = q.sleep_sel;
    assign o_pix_clk                 = q.pix_clk;
    assign o_return_link_checksum_en = q.crc_en;
    assign o_undriven_pull_down_sel  = q.pull_dn;
    assign o_fwd_ctrl                = q.fwd;
    assign o_auto_ack_en             = q.auto_ack;
    assign o_logic_reset             = q.lrst;
    assign o_logic_reset_busy        = q.busy_out;
    assign o_pixel_valid             = q.filt[SIG_VALID];
    assign o_line_sync               = q.filt[SIG_LINE];
    assign o_frame_sync              = q.filt[SIG_FRAME];
    assign o_pix_data                = q.pix_data;

    // Effective enable forced high without override
    oe_forced_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !q.cfg0[C0_OVR] |=> o_out_en)
        else $error("output enable not forced high");

    // Override passes stored sleep value one cycle later
    sleep_override_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        q.cfg0[C0_OVR] |=> o_sleep_sel == $past(q.cfg0[C0_SLEEP]))
        else $error("sleep select does not follow override value");

    // Sleep select forced high without override
    sleep_forced_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !q.cfg0[C0_OVR] |=> o_sleep_sel)
        else $error("sleep select not forced high");

    // Fallback clock follows oscillator when unlocked
    osc_fallback_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!i_lock && q.cfg0[C0_OSC_EN]) |=> o_pix_clk == $past(i_osc_clk_lvl))
        else $error("oscillator not driven on pixel clock");

    // Checksum and pull follow their bits
    crc_pull_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        ##1 (o_return_link_checksum_en == $past(q.cfg1[C1_CRC_EN]))
            && (o_undriven_pull_down_sel == $past(q.cfg1[C1_PULL_DN])))
        else $error("checksum or pull select mismatch");

    // Filtered valid changes only after the full depth
    filter_depth_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn || q.lrst)
        (q.cfg1[C1_FILT_EN] && $stable(q.cfg1) && $changed(q.filt[0])
            && $past(q.cfg1[C1_FILT_EN]))
        |-> $past(q.cnt[0]) == $past(depth) - 3'h1)
        else $error("pulse passed the filter too early");

    // Forwarding needs enable and address match
    forward_gate_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        o_fwd_ctrl |-> $past(q.cfg1[C1_PASS] && i_addr_match))
        else $error("forwarding without enable and match");

    // Auto acknowledge follows its bit
    auto_ack_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        ##1 o_auto_ack_en == $past(q.cfg1[C1_AUTOACK]))
        else $error("auto acknowledge mismatch");

    // Gated data is zero while valid is low
    data_gating_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (gate_on && !d.filt[SIG_VALID]) |=> o_pix_data == 24'h000000)
        else $error("pixel data not gated");

    // Logic reset starts busy and keeps registers
    logic_reset_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (q.lrst && !i_reg_wr) |=> o_logic_reset_busy && !o_logic_reset
            && $stable(q.cfg0) && $stable(q.cfg1))
        else $error("logic reset misbehaves");

    // Read returns the stored first register one cycle later
    read_back_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_reg_rd && i_reg_addr == ADDR_CFG0)
        |=> o_reg_rvalid && o_reg_rdata == $past(q.cfg0))
        else $error("read answer missing or wrong");

    // Second register stores the whole written byte
    write_store_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_reg_wr && i_reg_addr == ADDR_CFG1)
        |=> q.cfg1 == $past(i_reg_wdata))
        else $error("written byte not stored");

    // Unlocked without fallback the pixel clock stays low
    osc_off_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!i_lock && !q.cfg0[C0_OSC_EN]) |=> !o_pix_clk)
        else $error("pixel clock driven without fallback");

    // Locked pixel clock follows the recovered clock
    locked_clock_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        i_lock |=> o_pix_clk == $past(i_pix_clk_lvl))
        else $error("pixel clock not from recovered clock");

    // Forwarding follows enable and address match
    forward_on_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (q.cfg1[C1_PASS] && i_addr_match) |=> o_fwd_ctrl)
        else $error("forwarding not enabled");

    // Filter off passes every lane one cycle late
    filter_off_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!q.cfg1[C1_FILT_EN] && !q.lrst)
        |=> o_pixel_valid == $past(i_pix.pixel_valid)
            && o_line_sync == $past(i_pix.line_sync)
            && o_frame_sync == $past(i_pix.frame_sync))
        else $error("unfiltered lane not passed");

    // Logic reset clears the filtered lanes and the data
    reset_clears_a : assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        q.lrst |=> !o_pixel_valid && !o_line_sync && !o_frame_sync
            && o_pix_data == 24'h000000)
        else $error("logic reset left datapath state");

endmodule

`default_nettype wire

// *** verif/dgc_tb.sv ***
/*
 * Self-checking bench for the general configuration register pair.
 * Assumes dgc_pkg and dgc_regs are compiled first; the logic reset
 * settle count is cut to 16 cycles to keep the run short.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import dgc_pkg::*;

    localparam int LRST_N = 16;

    logic        i_clk_sys   = 1'b0;
    logic        i_rstn      = 1'b0;
    logic        i_reg_wr    = 1'b0;
    logic        i_reg_rd    = 1'b0;
    logic [7:0]  i_reg_addr  = 8'h00;
    logic [7:0]  i_reg_wdata = 8'h00;
    logic        i_lock      = 1'b1;
    logic        i_dual_lane = 1'b0;
    logic        i_ser_prot  = 1'b0;
    logic        i_addr_match = 1'b1;
    logic        i_pix_lvl   = 1'b1;
    logic        i_osc_lvl   = 1'b0;
    logic [2:0]  sync_in     = 3'h0;
    logic [23:0] data_in     = 24'habcdef;
    logic        pix_en      = 1'b1;
    dgc_pix_type pix_s;
    logic [7:0]  o_reg_rdata;
    logic        o_reg_rvalid, o_out_en, o_sleep_sel, o_pix_clk;
    logic        o_crc_en, o_pull_dn, o_fwd, o_ack, o_lrst, o_busy;
    wire  [2:0]  sync_out;
    logic [23:0] o_pix_data;
    int          err_total = 0;
    int          n_checks  = 0;
    int          busy_n, pulse_n;
    logic        seen;

    // Clock and pixel group assembly
    always #2 i_clk_sys = ~i_clk_sys;
    assign pix_s = '{pix_en, sync_in[0], sync_in[1], sync_in[2], data_in};

    dgc_regs #(.LRST_COUNT(LRST_N)) dut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_lock(i_lock), .i_dual_lane(i_dual_lane),
        .i_ser_protected(i_ser_prot), .i_addr_match(i_addr_match),
        .i_pix_clk_lvl(i_pix_lvl), .i_osc_clk_lvl(i_osc_lvl),
        .i_pix(pix_s), .o_out_en(o_out_en), .o_sleep_sel(o_sleep_sel),
        .o_pix_clk(o_pix_clk), .o_return_link_checksum_en(o_crc_en),
        .o_undriven_pull_down_sel(o_pull_dn), .o_fwd_ctrl(o_fwd),
        .o_auto_ack_en(o_ack), .o_logic_reset(o_lrst),
        .o_logic_reset_busy(o_busy), .o_pixel_valid(sync_out[0]),
        .o_line_sync(sync_out[1]), .o_frame_sync(sync_out[2]),
        .o_pix_data(o_pix_data)
    );

    // Verdict and end of run
    task automatic end_of_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compare helpers
    task automatic chkb(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chkd(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // Register port: one-cycle strobes set at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
        @(negedge i_clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        int k;
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        k = 0;
        while (o_reg_rvalid !== 1'b1 && k < 4) begin
            @(negedge i_clk_sys);
            k++;
        end
        n_checks++;
        if (o_reg_rvalid !== 1'b1 || o_reg_rdata !== exp) begin
            err_total++;
            $display("Error at %0t: read %h got %h", $time, a, o_reg_rdata);
        end
        @(negedge i_clk_sys);
    endtask

    // Pulse one sync input for n cycles and note if it came through
    task automatic pulse(input int k, input int n, output logic s);
        s = 1'b0;
        sync_in[k] = 1'b1;
        repeat (n) begin
            @(negedge i_clk_sys);
            s = s | sync_out[k];
        end
        sync_in[k] = 1'b0;
        repeat (8) begin
            @(negedge i_clk_sys);
            s = s | sync_out[k];
        end
        settle(8);
    endtask

    // Watchdog reckoned well past the expected few hundred cycles
    initial begin
        #40000;
        err_total++;
        end_of_test();
    end

    // Main sequence
    initial begin
        settle(10);
        i_rstn = 1'b1;
        settle(1);
        rd(ADDR_CFG0, CFG0_RST);
        rd(ADDR_CFG1, CFG1_RST);
        chkb(o_out_en, 1'b1);
        chkb(o_sleep_sel, 1'b1);
        chkb(o_crc_en, 1'b1);
        chkb(o_pull_dn, 1'b1);
        chkb(o_fwd, 1'b0);
        chkb(o_ack, 1'b0);
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h00);
        rd(ADDR_RESET, 8'h00);
        rd(ADDR_CFG0, CFG0_RST);
        wr(ADDR_CFG0, 8'h4f);
        settle(2);
        chkb(o_out_en, 1'b0);
        chkb(o_sleep_sel, 1'b0);
        rd(ADDR_CFG0, 8'h4f);
        wr(ADDR_CFG0, 8'h50);
        settle(2);
        chkb(o_sleep_sel, 1'b1);
        wr(ADDR_CFG0, 8'h0f);
        settle(2);
        chkb(o_out_en, 1'b1);
        chkb(o_sleep_sel, 1'b1);
        wr(ADDR_CFG0, 8'hc0);
        settle(2);
        chkb(o_sleep_sel, 1'b0);
        i_reg_wr = 1'b1;
        i_reg_addr = ADDR_RESET;
        i_reg_wdata = 8'h01;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
        busy_n = 0;
        pulse_n = int'(o_lrst === 1'b1);
        repeat (24) begin
            @(negedge i_clk_sys);
            busy_n += int'(o_busy === 1'b1);
            pulse_n += int'(o_lrst === 1'b1);
        end
        chkb(busy_n == LRST_N && pulse_n == 1, 1'b1);
        rd(ADDR_CFG0, 8'hc0);
        // Oscillator fallback on the pixel clock
        wr(ADDR_CFG0, 8'ha0);
        i_lock = 1'b0;
        i_osc_lvl = 1'b1;
        i_pix_lvl = 1'b0;
        settle(2);
        chkb(o_pix_clk, 1'b1);
        wr(ADDR_CFG0, 8'h80);
        settle(2);
        chkb(o_pix_clk, 1'b0);
        i_lock = 1'b1;
        i_pix_lvl = 1'b1;
        i_osc_lvl = 1'b0;
        settle(2);
        chkb(o_pix_clk, 1'b1);
        // Serial control and link flags
        wr(ADDR_CFG1, 8'h8d);
        settle(2);
        chkb(o_crc_en, 1'b0);
        chkb(o_pull_dn, 1'b0);
        chkb(o_fwd, 1'b1);
        chkb(o_ack, 1'b1);
        rd(ADDR_CFG1, 8'h8d);
        i_addr_match = 1'b0;
        settle(2);
        chkb(o_fwd, 1'b0);
        // Pixel gating with valid
        wr(ADDR_CFG1, 8'hf0);
        settle(2);
        chkd(o_pix_data, 24'habcdef);
        wr(ADDR_CFG1, 8'hf2);
        settle(2);
        chkd(o_pix_data, 24'h000000);
        sync_in[0] = 1'b1;
        settle(4);
        chkd(o_pix_data, 24'habcdef);
        sync_in[0] = 1'b0;
        wr(ADDR_CFG1, 8'hf0);
        i_ser_prot = 1'b1;
        settle(4);
        chkd(o_pix_data, 24'h000000);
        i_ser_prot = 1'b0;
        // Glitch filter: odd lengths fall short of the lane depth
        for (int k = 0; k < 3; k++) begin
            for (int j = 1; j <= 4; j++) begin
                i_dual_lane = (j > 2);
                pulse(k, j, seen);
                chkb(seen, j % 2 == 0);
            end
        end
        i_dual_lane = 1'b0;
        // No pixel clock ticks: the count must not advance
        pix_en = 1'b0;
        pulse(0, 4, seen);
        chkb(seen, 1'b0);
        pix_en = 1'b1;
        wr(ADDR_CFG1, 8'he0);
        settle(2);
        for (int k = 0; k < 3; k++) begin
            pulse(k, 1, seen);
            chkb(seen, 1'b1);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
